// ==== udw_pkg.sv ====
// Package for the up/down wiper host controller.
// Assumes a 25 MHz system clock; all timing counts derive from it.
package udw_pkg;
    localparam int CLK_MHZ = 25;
    localparam int TAP_W = 5;
    localparam logic [4:0] TAP_MAX = 5'h1f;
    localparam logic [4:0] TAP_MIN = 5'h00;
    localparam logic [4:0] TAP_DEFAULT = 5'h10;
    // Step high and low times on the up/down pin, in ns
    localparam int STEP_HIGH_NS = 100;
    localparam int STEP_LOW_NS = 100;
    // Programming timing in ms
    localparam int SUPPLY_TO_SEL_MS = 1;
    localparam int SEL_TO_SUPPLY_MS = 5;
    localparam int PROG_PULSE_HIGH_MS = 5;
    localparam int PROG_PULSE_LOW_MS = 5;
    localparam int SUPPLY_OFF_TO_SEL_MS = 1;
    localparam int STEP_HIGH_CYC = (STEP_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP_LOW_CYC = (STEP_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int MS_CYC = 1000 * CLK_MHZ;
    localparam logic [2:0] PULSES_STORE = 3'h5;
    localparam logic [2:0] PULSES_LOCK = 3'h6;
    localparam int CNT_W = 20;
    typedef enum logic [3:0] {
        UDW_IDLE, UDW_SEL, UDW_UP, UDW_DOWN, UDW_REL,
        UDW_P_UD, UDW_P_VPP, UDW_P_LOW, UDW_P_HIGH, UDW_P_VOFF, UDW_P_END
    } udw_state_type;
endpackage

// ==== udw_host.sv ====
// Host controller driving the select and up/down pins of an up/down wiper part.
// Assumes pins are direct outputs; the programming supply is switched by supply_en.
`timescale 1ns/10ps
// Notes on behaviour
// - Move, up/down high, supply on, select low.
// - Five select pulses store current position.
// - Return programming supply to zero afterwards.
// - Restore original tap before locking programmed part; the controller does not move the tap back itself.
module udw_host
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic move_req,
    input wire logic move_up,
    input wire logic [udw_pkg::TAP_W-1:0] move_steps,
    input wire logic prog_req,
    input wire logic prog_lock,
    output logic busy,
    output logic locked,
    output logic [udw_pkg::TAP_W-1:0] tap_pos,
    output logic sel_n,
    output logic updown,
    output logic supply_en
);
    import udw_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] ms_cycles(input int ms);
        ms_cycles = CNT_W'(ms * MS_CYC);
    endfunction

    function automatic logic [TAP_W-1:0] sat_step(input logic [TAP_W-1:0] t, input logic up);
        if (up)
            sat_step = (t == TAP_MAX) ? t : t + 5'h01;
        else
            sat_step = (t == TAP_MIN) ? t : t - 5'h01;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    udw_state_type state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [TAP_W-1:0] steps_q, steps_d;
    logic [TAP_W-1:0] tap_q, tap_d;
    logic [2:0] pulses_q, pulses_d;
    logic [2:0] target_q, target_d;
    logic dir_q, dir_d;
    logic sel_n_q, sel_n_d;
    logic ud_q, ud_d;
    logic sup_q, sup_d;
    logic lock_q, lock_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 20'h00001 : cnt_q;
        steps_d = steps_q;
        tap_d = tap_q;
        pulses_d = pulses_q;
        target_d = target_q;
        dir_d = dir_q;
        sel_n_d = sel_n_q;
        ud_d = ud_q;
        sup_d = sup_q;
        lock_d = lock_q;
        case (state_q)
            UDW_IDLE:
            begin
                if (lock_q)
                begin
                    state_d = UDW_IDLE;
                end
                else if (prog_req)
                begin
                    target_d = prog_lock ? PULSES_LOCK : PULSES_STORE;
                    ud_d = 1'b1;
                    cnt_d = CNT_W'(STEP_HIGH_CYC);
                    state_d = UDW_P_UD;
                end
                else if (move_req && move_steps != '0)
                begin
                    dir_d = move_up;
                    ud_d = move_up;
                    steps_d = move_steps;
                    cnt_d = CNT_W'(STEP_HIGH_CYC);
                    state_d = UDW_SEL;
                end
            end
            UDW_SEL:
            begin
                if (cnt_q == '0)
                begin
                    // Direction stays on up/down past the select fall, as hold time
                    sel_n_d = 1'b0;
                    cnt_d = CNT_W'(STEP_HIGH_CYC);
                    state_d = UDW_UP;
                end
            end
            UDW_DOWN:
            begin
                if (cnt_q == '0)
                begin
                    ud_d = 1'b1;
                    tap_d = sat_step(tap_q, dir_q);
                    steps_d = steps_q - 5'h01;
                    cnt_d = CNT_W'(STEP_HIGH_CYC);
                    state_d = UDW_UP;
                end
            end
            UDW_UP:
            begin
                if (cnt_q == '0)
                begin
                    if (steps_q == '0)
                    begin
                        sel_n_d = 1'b1;
                        cnt_d = CNT_W'(STEP_HIGH_CYC);
                        state_d = UDW_REL;
                    end
                    else
                    begin
                        ud_d = 1'b0;
                        cnt_d = CNT_W'(STEP_LOW_CYC);
                        state_d = UDW_DOWN;
                    end
                end
            end
            UDW_REL:
            begin
                if (cnt_q == '0)
                begin
                    ud_d = 1'b0;
                    state_d = UDW_IDLE;
                end
            end
            UDW_P_UD:
            begin
                if (cnt_q == '0)
                begin
                    sup_d = 1'b1;
                    cnt_d = ms_cycles(SUPPLY_TO_SEL_MS);
                    state_d = UDW_P_VPP;
                end
            end
            UDW_P_VPP:
            begin
                if (cnt_q == '0)
                begin
                    sel_n_d = 1'b0;
                    pulses_d = '0;
                    cnt_d = ms_cycles(PROG_PULSE_LOW_MS);
                    state_d = UDW_P_LOW;
                end
            end
            UDW_P_LOW:
            begin
                if (cnt_q == '0)
                begin
                    if (pulses_q == target_q)
                    begin
                        sup_d = 1'b0;
                        cnt_d = ms_cycles(SUPPLY_OFF_TO_SEL_MS);
                        state_d = UDW_P_VOFF;
                    end
                    else
                    begin
                        sel_n_d = 1'b1;
                        cnt_d = ms_cycles(PROG_PULSE_HIGH_MS);
                        state_d = UDW_P_HIGH;
                    end
                end
            end
            UDW_P_HIGH:
            begin
                if (cnt_q == '0)
                begin
                    sel_n_d = 1'b0;
                    pulses_d = pulses_q + 3'h1;
                    cnt_d = ms_cycles(PROG_PULSE_LOW_MS);
                    state_d = UDW_P_LOW;
                end
            end
            UDW_P_VOFF:
            begin
                if (cnt_q == '0)
                begin
                    sel_n_d = 1'b1; // up/down is high, so no extra step
                    cnt_d = CNT_W'(STEP_HIGH_CYC);
                    state_d = UDW_P_END;
                end
            end
            UDW_P_END:
            begin
                if (cnt_q == '0)
                begin
                    ud_d = 1'b0;
                    lock_d = (target_q == PULSES_LOCK);
                    state_d = UDW_IDLE;
                end
            end
            default:
            begin
                state_d = UDW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= UDW_IDLE;
            cnt_q <= '0;
            steps_q <= '0;
            tap_q <= TAP_DEFAULT;
            pulses_q <= '0;
            target_q <= PULSES_STORE;
            dir_q <= 1'b0;
            sel_n_q <= 1'b1;
            ud_q <= 1'b0;
            sup_q <= 1'b0;
            lock_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            steps_q <= steps_d;
            tap_q <= tap_d;
            pulses_q <= pulses_d;
            target_q <= target_d;
            dir_q <= dir_d;
            sel_n_q <= sel_n_d;
            ud_q <= ud_d;
            sup_q <= sup_d;
            lock_q <= lock_d;
        end
    end

    assign busy = (state_q != UDW_IDLE);
    assign locked = lock_q;
    assign tap_pos = tap_q;
    assign sel_n = sel_n_q;
    assign updown = ud_q;
    assign supply_en = sup_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sel_fall_dir_a: assert property (@(posedge sys_clk) disable iff (reset)
        ($fell(sel_n) && !supply_en) |-> (updown == dir_q))
        else $error("Direction not presented at select fall");
    no_extra_step_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(sel_n) |-> updown)
        else $error("Select rose with up/down low");
    prog_order_a: assert property (@(posedge sys_clk) disable iff (reset)
        ($fell(sel_n) && supply_en) |-> updown)
        else $error("Programming select fall without up/down high");
    supply_first_a: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == UDW_P_HIGH) |-> supply_en)
        else $error("Programming pulse without supply");
    lock_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
        locked |-> (sel_n && !supply_en && state_q == UDW_IDLE))
        else $error("Activity after lock");
    sat_top_a: assert property (@(posedge sys_clk) disable iff (reset)
        ($past(tap_q) == TAP_MAX && $past(dir_q) && $rose(updown) && !sel_n) |-> tap_q == TAP_MAX)
        else $error("Tap wrapped at top");
endmodule

// ==== udw_dev_model.sv ====
// Behavioural model of the up/down wiper part seen from its pins.
// Assumes por is high while power is cycled; the supply pin is a plain level.
`timescale 1ns/10ps
module udw_dev_model
(
    input wire logic sel_n,
    input wire logic updown,
    input wire logic supply_en,
    input wire logic por,
    output logic [4:0] wiper
);
    // -----------------------------
    // Wiper counter and fuses
    // -----------------------------
    logic dir_up = 1'b0;
    logic lock_bit = 1'b0;
    logic prog_done = 1'b0;
    logic [4:0] stored = 5'h10;
    logic [4:0] wiper_v = 5'h10;
    logic sel_p = 1'b1;
    logic ud_p = 1'b0;
    logic sup_p = 1'b0;
    logic por_p = 1'b0;
    int pulses = 0;
    assign wiper = wiper_v;
    function automatic logic [4:0] step(input logic [4:0] w, input logic up);
        if (up)
            return (w == 5'h1f) ? w : w + 5'h01;
        return (w == 5'h00) ? w : w - 5'h01;
    endfunction
    // One process owns all state; pin edges are found against the last levels seen
    // Power-up load; holds between sessions otherwise
    always @(sel_n or updown or supply_en or por)
    begin
        if (por && !por_p)
            wiper_v = prog_done ? stored : 5'h10;
        if (!por && !lock_bit)
        begin
            if (!sel_n && sel_p && !supply_en)
                dir_up = updown;
            if (updown && !ud_p && !sel_n && !supply_en)
                wiper_v = step(wiper_v, dir_up);
            if (sel_n && !sel_p)
            begin
                if (supply_en)
                    pulses++;
                else if (!updown)
                    wiper_v = step(wiper_v, dir_up);
            end
        end
        if (!supply_en && sup_p)
        begin
            if (!lock_bit && pulses >= 5)
            begin
                stored = wiper_v;
                prog_done = 1'b1;
                lock_bit = (pulses >= 6);
            end
            pulses = 0;
        end
        sel_p = sel_n;
        ud_p = updown;
        sup_p = supply_en;
        por_p = por;
    end
endmodule

// ==== test_updown_wiper_otp_control.sv ====
// Self-checking bench for the up/down wiper host controller.
// Assumes the pin model udw_dev_model; programming is only entered, not finished.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module test_updown_wiper_otp_control;
    import udw_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic move_req = 1'b0;
    logic move_up = 1'b0;
    logic [4:0] move_steps = 5'h00;
    logic prog_req = 1'b0;
    logic prog_lock = 1'b0;
    logic busy, locked, sel_n, updown, supply_en;
    logic [4:0] tap_pos, wiper;
    int fail_count = 0;
    int n_compared = 0;
    int exp_tap = 16;
    int t_sup;
    udw_host i_dut (.sys_clk(sys_clk), .reset(reset), .move_req(move_req),
        .move_up(move_up), .move_steps(move_steps), .prog_req(prog_req),
        .prog_lock(prog_lock), .busy(busy), .locked(locked), .tap_pos(tap_pos),
        .sel_n(sel_n), .updown(updown), .supply_en(supply_en));
    udw_dev_model i_dev (.sel_n(sel_n), .updown(updown), .supply_en(supply_en),
        .por(reset), .wiper(wiper));
    initial forever #20 sys_clk = ~sys_clk;
    // -----------------------------
    // Tasks
    // -----------------------------
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000 && busy !== 1'b0; i++)
            @(negedge sys_clk);
        if (i == 2000)
        begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic do_move(input logic up, input logic [4:0] n, input logic poke);
        @(negedge sys_clk);
        move_req = 1'b1;
        move_up = up;
        move_steps = n;
        @(negedge sys_clk);
        move_req = poke;
        move_up = ~up;
        `CHK(busy, n != 5'h00)
        repeat (2) @(negedge sys_clk);
        move_req = 1'b0;
        wait_idle();
        for (int i = 0; i < n; i++)
            exp_tap = up ? (exp_tap < 31 ? exp_tap + 1 : 31) : (exp_tap > 0 ? exp_tap - 1 : 0);
        `CHK(tap_pos, 5'(exp_tap))
        `CHK(wiper, 5'(exp_tap))
        `CHK(sel_n, 1'b1)
    endtask
    // -----------------------------
    // Main sequence
    // -----------------------------
    initial
    begin
        void'($urandom(32'hd7f57dea));
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        `CHK(tap_pos, 5'h10)
        do_move(1'b1, 5'h1f, 1'b1);
        do_move(1'b1, 5'h01, 1'b0);
        do_move(1'b0, 5'h1f, 1'b0);
        do_move(1'b0, 5'h02, 1'b0);
        do_move(1'b1, 5'h00, 1'b0);
        repeat (14) do_move(1'($urandom), 5'($urandom), 1'($urandom));
        @(negedge sys_clk);
        prog_req = 1'b1;
        @(negedge sys_clk);
        prog_req = 1'b0;
        t_sup = -1;
        for (int i = 0; i < 30000; i++)
        begin
            if (t_sup < 0 && supply_en === 1'b1)
            begin
                t_sup = i;
                `CHK(updown, 1'b1)
                `CHK(sel_n, 1'b1)
            end
            if (sel_n === 1'b0)
            begin
                `CHK(i - t_sup >= MS_CYC && t_sup >= 0, 1'b1)
                break;
            end
            @(negedge sys_clk);
            if (i == 29999)
            begin
                fail_count++;
                give_verdict();
            end
        end
        `CHK(wiper, 5'(exp_tap))
        reset = 1'b1;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        exp_tap = 16;
        `CHK(supply_en, 1'b0)
        `CHK(locked, 1'b0)
        `CHK(wiper, 5'h10)
        do_move(1'b0, 5'h05, 1'b0);
        give_verdict();
    end
endmodule
